// File: acs_ctrl.sv
/*
 * Gain control loop and carrier sense detection with its three control registers.
 * Assumes channel filter amplitude samples in whole dB, synchronous to clk_in.
 */
`timescale 1ns/1ns

module acs_ctrl
	import acs_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic [5:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	input  wire logic       sample_valid_in,
	input  wire logic [7:0] sample_amp_in,
	input  wire logic       sync_found_in,
	input  wire logic       rx_restart_in,
	input  wire acs_gain_t  manual_gain_in,
	output acs_gain_t       gain_out,
	output logic      [7:0] avg_amp_out,
	output logic      [9:0] rssi_out,
	output logic            carrier_sense_out,
	output logic      [4:0] ook_boundary_db_out,
	output logic            gain_held_out
);

	logic [2:0]  target_amplitude_sel_q;
	logic [7:0]  ctrl1_q;
	logic [7:0]  ctrl0_q;
	logic [7:0]  rdata_q;
	acs_state_t  state_q;
	logic [6:0]  cnt_q;
	logic [13:0] acc_q;
	logic [7:0]  avg_q;
	acs_gain_t   gain_q;
	logic        sync_hold_q;
	logic [9:0]  ref_q;
	logic        cs_q;

	logic        gain_reduction_order_sel;
	logic [1:0]  cs_relative_threshold;
	logic [3:0]  cs_absolute_threshold;
	logic [1:0]  gain_hysteresis_sel;
	logic [1:0]  settle_sel;
	logic [1:0]  gain_hold_mode;
	logic [1:0]  avg_len_sel;

	assign gain_reduction_order_sel = ctrl1_q[ACS_PRIO_BIT];
	assign cs_relative_threshold    = ctrl1_q[ACS_REL_LSB +: 2];
	assign cs_absolute_threshold    = ctrl1_q[ACS_ABS_LSB +: 4];
	assign gain_hysteresis_sel      = ctrl0_q[ACS_HYST_LSB +: 2];
	assign settle_sel               = ctrl0_q[ACS_WAIT_LSB +: 2];
	assign gain_hold_mode           = ctrl0_q[ACS_HOLD_LSB +: 2];
	assign avg_len_sel              = ctrl0_q[ACS_FLEN_LSB +: 2];

	logic [6:0]  avg_len;
	logic [6:0]  settle_len;
	logic [13:0] sum_w;
	logic [7:0]  avg_now;
	logic        win_done;
	logic [9:0]  target_db;
	logic [9:0]  rssi_now;
	logic        too_high;
	logic        too_low;
	logic        analog_frozen;
	logic        digital_frozen;
	logic        analog_min;
	logic        analog_max;
	acs_gain_t   gain_d;
	logic        stepped;
	logic        cs_abs_w;
	logic        cs_rel_w;
	logic [9:0]  abs_thr;
	logic [9:0]  rel_thr;

	assign avg_len    = 7'h08 << avg_len_sel;
	assign settle_len = {2'h0, settle_sel, 3'h0} + 7'h08;
	assign sum_w      = acc_q + {6'h00, sample_amp_in};
	assign avg_now    = 8'(sum_w >> (3 + avg_len_sel));
	assign win_done   = sample_valid_in && (state_q == ACS_MEASURE) && (cnt_q == avg_len - 7'h01);
	assign target_db  = acs_target_db(target_amplitude_sel_q);

	// amplitude put back on the input scale by the gain already taken away
	assign rssi_now = {2'h0, avg_now} + ACS_GAIN_STEP * 10'(5'(3 * ACS_GAIN_MAX)
		- 5'(gain_q.lna1) - 5'(gain_q.second_front_amp_gain)
		- 5'(gain_q.digital_variable_gain_stage));

	assign too_high = {2'h0, avg_now} > target_db + acs_dz_hi(gain_hysteresis_sel);
	assign too_low  = {2'h0, avg_now} + acs_dz_lo(gain_hysteresis_sel) < target_db;

	assign analog_frozen  = (gain_hold_mode == ACS_HOLD_ANALOG) || (gain_hold_mode == ACS_HOLD_ALL)
		|| (gain_hold_mode == ACS_HOLD_SYNC && sync_hold_q);
	assign digital_frozen = (gain_hold_mode == ACS_HOLD_ALL)
		|| (gain_hold_mode == ACS_HOLD_SYNC && sync_hold_q);
	assign analog_min = (gain_q.lna1 == 3'h0) && (gain_q.second_front_amp_gain == 3'h0);
	assign analog_max = (gain_q.lna1 == ACS_GAIN_MAX) && (gain_q.second_front_amp_gain == ACS_GAIN_MAX);

	// increases undo reductions in reverse order: digital first, then analogue
	always_comb begin
		gain_d = gain_q;
		if (win_done && too_high) begin
			if (!analog_frozen && !analog_min) begin
				if (gain_reduction_order_sel) begin
					if (gain_q.lna1 != 3'h0) begin
						gain_d.lna1 = gain_q.lna1 - 3'h1;
					end else begin
						gain_d.second_front_amp_gain = gain_q.second_front_amp_gain - 3'h1;
					end
				end else begin
					if (gain_q.second_front_amp_gain != 3'h0) begin
						gain_d.second_front_amp_gain = gain_q.second_front_amp_gain - 3'h1;
					end else begin
						gain_d.lna1 = gain_q.lna1 - 3'h1;
					end
				end
			end else if (!digital_frozen && gain_q.digital_variable_gain_stage != 3'h0) begin
				gain_d.digital_variable_gain_stage = gain_q.digital_variable_gain_stage - 3'h1;
			end
		end else if (win_done && too_low) begin
			if (!digital_frozen && gain_q.digital_variable_gain_stage != ACS_GAIN_MAX) begin
				gain_d.digital_variable_gain_stage = gain_q.digital_variable_gain_stage + 3'h1;
			end else if (!analog_frozen && !analog_max) begin
				if (gain_reduction_order_sel) begin
					if (gain_q.second_front_amp_gain != ACS_GAIN_MAX) begin
						gain_d.second_front_amp_gain = gain_q.second_front_amp_gain + 3'h1;
					end else begin
						gain_d.lna1 = gain_q.lna1 + 3'h1;
					end
				end else begin
					if (gain_q.lna1 != ACS_GAIN_MAX) begin
						gain_d.lna1 = gain_q.lna1 + 3'h1;
					end else begin
						gain_d.second_front_amp_gain = gain_q.second_front_amp_gain + 3'h1;
					end
				end
			end
		end
	end

	assign stepped = (gain_d != gain_q) && (gain_hold_mode != ACS_HOLD_ALL);

	// register port
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			target_amplitude_sel_q <= ACS_TARGET_RST;
			ctrl1_q                <= ACS_CTRL1_RST;
			ctrl0_q                <= ACS_CTRL0_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ACS_ADDR_TARGET: target_amplitude_sel_q <= reg_wdata_in[2:0];
				ACS_ADDR_CTRL1:  ctrl1_q <= {1'b0, reg_wdata_in[6:0]};
				ACS_ADDR_CTRL0:  ctrl0_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// other fields of the target register belong elsewhere and read as zero here
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				ACS_ADDR_TARGET: rdata_q <= {5'h00, target_amplitude_sel_q};
				ACS_ADDR_CTRL1:  rdata_q <= ctrl1_q;
				ACS_ADDR_CTRL0:  rdata_q <= ctrl0_q;
				default:         rdata_q <= 8'h00;
			endcase
		end
	end

	// averaging window and post-step settling
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q <= ACS_MEASURE;
			cnt_q   <= 7'h00;
			acc_q   <= 14'h0000;
			avg_q   <= 8'h00;
		end else if (rx_restart_in) begin
			state_q <= ACS_MEASURE;
			cnt_q   <= 7'h00;
			acc_q   <= 14'h0000;
		end else if (sample_valid_in) begin
			case (state_q)
				ACS_MEASURE: begin
					if (win_done) begin
						avg_q   <= avg_now;
						cnt_q   <= 7'h00;
						acc_q   <= 14'h0000;
						state_q <= stepped ? ACS_SETTLE : ACS_MEASURE;
					end else begin
						cnt_q <= cnt_q + 7'h01;
						acc_q <= sum_w;
					end
				end
				ACS_SETTLE: begin
					if (cnt_q == settle_len - 7'h01) begin
						cnt_q   <= 7'h00;
						state_q <= ACS_MEASURE;
					end else begin
						cnt_q <= cnt_q + 7'h01;
					end
				end
				default: state_q <= ACS_MEASURE;
			endcase
		end
	end

	// gain setting
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			gain_q <= '{ACS_GAIN_MAX, ACS_GAIN_MAX, ACS_GAIN_MAX};
		end else if (gain_hold_mode == ACS_HOLD_ALL) begin
			gain_q <= manual_gain_in;
		end else begin
			gain_q <= gain_d;
		end
	end

	// sync hold; a sync in the restart cycle still wins
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sync_hold_q <= 1'b0;
		end else if (sync_found_in && gain_hold_mode == ACS_HOLD_SYNC) begin
			sync_hold_q <= 1'b1;
		end else if (rx_restart_in) begin
			sync_hold_q <= 1'b0;
		end
	end

	// carrier sense
	assign abs_thr  = target_db + {{6{cs_absolute_threshold[3]}}, cs_absolute_threshold};
	assign cs_abs_w = (cs_absolute_threshold != ACS_ABS_OFF) && (rssi_now >= abs_thr);
	assign rel_thr  = (ref_q == ACS_REF_INIT) ? ACS_REF_INIT
		: ref_q + {6'h0, cs_relative_threshold, 2'h0} + 10'h002;
	assign cs_rel_w = (cs_relative_threshold != 2'h0) && (rssi_now >= rel_thr);

	// reference is the quietest level since restart; a strong start never counts as a rise
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ref_q <= ACS_REF_INIT;
			cs_q  <= 1'b0;
		end else if (rx_restart_in) begin
			ref_q <= ACS_REF_INIT;
			cs_q  <= 1'b0;
		end else if (win_done) begin
			if (rssi_now < ref_q) begin
				ref_q <= rssi_now;
			end
			cs_q <= cs_abs_w || cs_rel_w;
		end
	end

	assign reg_rdata_out       = rdata_q;
	assign gain_out            = gain_q;
	assign avg_amp_out         = avg_q;
	assign rssi_out            = rssi_now;
	assign carrier_sense_out   = cs_q;
	assign ook_boundary_db_out = {1'b0, avg_len_sel, 2'h0} + 5'h04;
	assign gain_held_out       = digital_frozen;

	default clocking acs_cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence step_taken;
		win_done && stepped && !rx_restart_in;
	endsequence
	sequence settling;
		state_q == ACS_SETTLE;
	endsequence

	order_first_a: assert property (win_done && too_high && !analog_frozen && gain_hold_mode != ACS_HOLD_ALL
		&& gain_reduction_order_sel && gain_q.lna1 != 3'h0 |=> gain_q.lna1 == $past(gain_q.lna1) - 3'h1
		&& $stable(gain_q.second_front_amp_gain)) else $error("first amp not lowered first");
	order_second_a: assert property (win_done && too_high && !analog_frozen && gain_hold_mode != ACS_HOLD_ALL
		&& !gain_reduction_order_sel && gain_q.second_front_amp_gain != 3'h0
		|=> $stable(gain_q.lna1)) else $error("first amp moved before second at min");
	rel_off_a: assert property (win_done && cs_relative_threshold == 2'h0
		&& !rx_restart_in && !cs_abs_w |=> !cs_q)
		else $error("relative sense active while off");
	abs_level_a: assert property (win_done && !rx_restart_in && cs_absolute_threshold != ACS_ABS_OFF
		&& rssi_now >= abs_thr |=> cs_q) else $error("absolute threshold missed");
	abs_off_a: assert property (win_done && cs_absolute_threshold == ACS_ABS_OFF
		&& !rx_restart_in && !cs_rel_w |=> !cs_q)
		else $error("absolute sense active while off");
	dead_zone_a: assert property (win_done && !too_high && !too_low && gain_hold_mode != ACS_HOLD_ALL
		|=> $stable(gain_q)) else $error("gain moved inside dead zone");
	settle_wait_a: assert property (step_taken |=> settling [*8])
		else $error("settling shorter than eight samples");
	normal_adjust_a: assert property (gain_hold_mode == ACS_HOLD_NONE && win_done && too_high
		&& gain_q.digital_variable_gain_stage != 3'h0 |=> gain_q != $past(gain_q))
		else $error("gain not adjusted in normal mode");
	sync_freeze_a: assert property (gain_hold_mode == ACS_HOLD_SYNC && sync_hold_q
		|=> $stable(gain_q)) else $error("gain moved after sync");
	analog_freeze_a: assert property (gain_hold_mode == ACS_HOLD_ANALOG
		|=> $stable(gain_q.lna1) && $stable(gain_q.second_front_amp_gain))
		else $error("analogue gain moved while held");
	manual_gain_a: assert property (gain_hold_mode == ACS_HOLD_ALL |=> gain_q == $past(manual_gain_in))
		else $error("manual gain not applied");
	ook_bound_a: assert property (ook_boundary_db_out == 5'(4 * int'(avg_len_sel) + 4))
		else $error("keying boundary not four dB per step");
	target_reset_a: assert property ($rose(reset_n_in) |-> target_amplitude_sel_q == ACS_TARGET_RST)
		else $error("target select reset wrong");
	cs_or_a: assert property ($rose(cs_q) |-> $past(cs_abs_w || cs_rel_w))
		else $error("carrier sense without a detector");

endmodule // acs_ctrl

// File: acs_pkg.sv
/*
 * Constants and types for the gain control and carrier sense configuration block.
 * Assumes a single clock domain and register access through the device register port.
 */
package acs_pkg;

	localparam logic [5:0] ACS_ADDR_TARGET = 6'h1b;
	localparam logic [5:0] ACS_ADDR_CTRL1  = 6'h1c;
	localparam logic [5:0] ACS_ADDR_CTRL0  = 6'h1d;

	localparam logic [2:0] ACS_TARGET_RST  = 3'h3;
	localparam logic [7:0] ACS_CTRL1_RST   = 8'h40;
	localparam logic [7:0] ACS_CTRL0_RST   = 8'h91;

	localparam int ACS_PRIO_BIT = 6;
	localparam int ACS_REL_LSB  = 4;
	localparam int ACS_ABS_LSB  = 0;
	localparam int ACS_HYST_LSB = 6;
	localparam int ACS_WAIT_LSB = 4;
	localparam int ACS_HOLD_LSB = 2;
	localparam int ACS_FLEN_LSB = 0;

	localparam logic [3:0] ACS_ABS_OFF     = 4'h8;
	localparam logic [2:0] ACS_GAIN_MAX    = 3'h7;
	localparam logic [9:0] ACS_GAIN_STEP   = 10'h003;
	localparam logic [9:0] ACS_REF_INIT    = 10'h3ff;
	localparam logic [1:0] ACS_HOLD_NONE   = 2'h0;
	localparam logic [1:0] ACS_HOLD_SYNC   = 2'h1;
	localparam logic [1:0] ACS_HOLD_ANALOG = 2'h2;
	localparam logic [1:0] ACS_HOLD_ALL    = 2'h3;

	typedef struct packed {
		logic [2:0] lna1;
		logic [2:0] second_front_amp_gain;
		logic [2:0] digital_variable_gain_stage;
	} acs_gain_t;

	typedef enum logic {ACS_MEASURE, ACS_SETTLE} acs_state_t;

	function automatic logic [9:0] acs_target_db(input logic [2:0] sel);
		case (sel)
			3'h0: acs_target_db = 10'h018;
			3'h1: acs_target_db = 10'h01b;
			3'h2: acs_target_db = 10'h01e;
			3'h3: acs_target_db = 10'h021;
			3'h4: acs_target_db = 10'h024;
			3'h5: acs_target_db = 10'h026;
			3'h6: acs_target_db = 10'h028;
			default: acs_target_db = 10'h02a;
		endcase
	endfunction

	// dead zone above and below target, equal at setting 0 and wider upward from setting 1 so gain drops less eagerly
	function automatic logic [9:0] acs_dz_hi(input logic [1:0] sel);
		case (sel)
			2'h0: acs_dz_hi = 10'h002;
			2'h1: acs_dz_hi = 10'h003;
			2'h2: acs_dz_hi = 10'h005;
			default: acs_dz_hi = 10'h008;
		endcase
	endfunction

	function automatic logic [9:0] acs_dz_lo(input logic [1:0] sel);
		case (sel)
			2'h0: acs_dz_lo = 10'h002;
			2'h1: acs_dz_lo = 10'h002;
			2'h2: acs_dz_lo = 10'h003;
			default: acs_dz_lo = 10'h004;
		endcase
	endfunction

endpackage

// File: acs_ctrl_tb_top.sv
/*
 * self-checking bench for acs_ctrl: registers, gain loop, carrier sense, hold modes.
 * assumes acs_pkg and acs_ctrl compiled first; a single 250 MHz clock.
 */
`timescale 1ns/1ns
module acs_ctrl_tb_top
	import acs_pkg::*;
;
	typedef struct packed {acs_gain_t g; logic [7:0] a; logic c; logic k;} acs_note_t;
	logic      clk_in, reset_n_in, reg_wr_in, reg_rd_in, sample_valid_in;
	logic      sync_found_in, rx_restart_in, carrier_sense_out, gain_held_out;
	logic [5:0] reg_addr_in;
	logic [7:0] reg_wdata_in, sample_amp_in, reg_rdata_out, avg_amp_out, rv;
	logic [9:0] rssi_out;
	logic [4:0] ook_boundary_db_out;
	acs_gain_t manual_gain_in, gain_out, m_gain;
	acs_note_t nt, win_q[$];
	logic [7:0] rd_q[$];
	logic [9:0] rs_q[$];
	logic      rd_took, win_last, w0, w1, m_prio, m_sync, m_ref_v;
	logic [1:0] m_hyst, m_wait, m_mode, m_rel, m_flen;
	logic [3:0] m_abs;
	logic [3:0] codes[6] = '{4'hf, 4'h1, 4'h9, 4'h7, 4'h0, 4'h8};
	int        dzhi[4] = '{2, 3, 5, 8};
	int        fail_count, cmp_count, cycles, seed, m_ref;

	acs_ctrl DUT (.clk_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
		.reg_rdata_out, .sample_valid_in, .sample_amp_in, .sync_found_in, .rx_restart_in,
		.manual_gain_in, .gain_out, .avg_amp_out, .rssi_out, .carrier_sense_out,
		.ook_boundary_db_out, .gain_held_out);

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// results land one cycle after the taking edge; negedge keeps clear of races
	always @(posedge clk_in) begin
		rd_took <= reg_rd_in;
		w0 <= win_last & sample_valid_in;
		w1 <= w0;
		cycles <= cycles + 1;
		if (cycles >= 20000) begin
			fail_count++;
			close_out();
		end
	end

	always @(negedge clk_in) begin
		if (rd_took && rd_q.size() > 0)
			cmp("read data", 10'(rd_q.pop_front()), 10'(reg_rdata_out));
		// rssi only means anything in the cycle that closes a window
		if (win_last && sample_valid_in && rs_q.size() > 0)
			cmp("rssi", rs_q.pop_front(), rssi_out);
		if (w1 && win_q.size() > 0) begin
			nt = win_q.pop_front();
			cmp("gain", 10'(nt.g), 10'(gain_out));
			cmp("average", 10'(nt.a), 10'(avg_amp_out));
			if (nt.k)
				cmp("carrier sense", 10'(nt.c), 10'(carrier_sense_out));
		end
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
	endtask

	task automatic cfg0(input logic [7:0] d);
		wr(ACS_ADDR_CTRL0, d);
		{m_hyst, m_wait, m_mode, m_flen} = d;
	endtask

	task automatic cfg1(input logic [7:0] d);
		wr(ACS_ADDR_CTRL1, d);
		{m_prio, m_rel, m_abs} = d[6:0];
	endtask

	task automatic pulse(input logic s);
		@(posedge clk_in);
		sync_found_in <= s;
		rx_restart_in <= !s;
		@(posedge clk_in);
		sync_found_in <= 1'b0;
		rx_restart_in <= 1'b0;
	endtask

	task automatic reset_all;
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		reset_n_in <= 1'b1;
		m_gain = 9'h1ff;
		{m_sync, m_ref_v} = 2'b00;
		{m_prio, m_rel, m_abs} = 7'h40;
		{m_hyst, m_wait, m_mode, m_flen} = 8'h91;
	endtask

	// 3 dB per step below maximum, over all three stages
	function automatic int rem();
		return 3 * (21 - int'(m_gain.lna1) - int'(m_gain.second_front_amp_gain)
			- int'(m_gain.digital_variable_gain_stage));
	endfunction

	task automatic feed(input logic [7:0] amp, input int n, input logic rnd, input logic last,
		output int sum);
		logic [7:0] a;
		sum = 0;
		for (int i = 0; i < n; i++) begin
			a = rnd ? 8'(31 + {$random(seed)} % 5) : amp;
			sum += a;
			if (last && i == n - 1)
				rs_q.push_back(10'(sum / n + rem()));
			@(posedge clk_in);
			sample_valid_in <= 1'b1;
			sample_amp_in <= a;
			win_last <= last && (i == n - 1);
		end
		@(posedge clk_in);
		sample_valid_in <= 1'b0;
		win_last <= 1'b0;
	endtask

	// one averaging window; settling is fed with a loud level so a short wait shows
	task automatic window(input logic [7:0] amp, input logic rnd);
		int sum, avg, rssi;
		logic csa, csr, k;
		acs_gain_t g0;
		feed(amp, 8 << m_flen, rnd, 1'b1, sum);
		avg = sum / (8 << m_flen);
		rssi = avg + rem();
		csa = (m_abs != 4'h8) && (rssi >= 33 + int'(signed'(m_abs)));
		csr = (m_rel != 2'h0) && m_ref_v && (rssi >= m_ref + 2 + 4 * int'(m_rel));
		k = (m_rel == 2'h0) || m_ref_v;
		g0 = m_gain;
		if (avg > 33 + dzhi[m_hyst] && m_mode != 2'h3 && !(m_mode == 2'h1 && m_sync)) begin
			if (m_mode == 2'h2 || m_gain[8:3] == 6'h00) begin
				if (m_gain.digital_variable_gain_stage != 3'h0)
					m_gain.digital_variable_gain_stage--;
			end else if ((m_prio && m_gain.lna1 != 3'h0) || m_gain.second_front_amp_gain == 3'h0)
				m_gain.lna1--;
			else
				m_gain.second_front_amp_gain--;
		end
		if (!m_ref_v || rssi < m_ref)
			m_ref = rssi;
		m_ref_v = 1'b1;
		win_q.push_back(acs_note_t'{m_gain, 8'(avg), csa | csr, k});
		if (m_gain != g0)
			feed(8'h3c, 8 + 8 * int'(m_wait), 1'b0, 1'b0, sum);
	endtask

	initial begin
		{reset_n_in, reg_wr_in, reg_rd_in, sample_valid_in, sync_found_in} = 5'h0;
		{rx_restart_in, win_last} = 2'h0;
		{reg_addr_in, reg_wdata_in, sample_amp_in} = 22'h0;
		manual_gain_in = 9'h0;
		{fail_count, cmp_count} = 0;
		seed = 32'h21fe;
		reset_all();
		rd(ACS_ADDR_TARGET, 8'h03);
		rd(ACS_ADDR_CTRL1, 8'h40);
		rd(ACS_ADDR_CTRL0, 8'h91);
		rd(6'h00, 8'h00);
		wr(ACS_ADDR_CTRL1, 8'hff);
		rd(ACS_ADDR_CTRL1, 8'h7f);
		rv = 8'($random(seed));
		wr(ACS_ADDR_CTRL0, rv);
		rd(ACS_ADDR_CTRL0, rv);
		for (int f = 0; f < 4; f++) begin
			wr(ACS_ADDR_CTRL0, 8'(f));
			@(negedge clk_in);
			cmp("ook boundary", 10'(4 * (f + 1)), 10'(ook_boundary_db_out));
		end
		for (int p = 1; p >= 0; p--) begin
			reset_all();
			cfg0(8'h00);
			cfg1(p ? 8'h48 : 8'h08);
			repeat (8) window(8'h3c, 1'b0);
		end
		reset_all();
		cfg0(8'h00);
		foreach (codes[i]) begin
			cfg1({4'h4, codes[i]});
			window(8'h21, 1'b0);
			window(8'h00, 1'b1);
		end
		cfg0(8'h03);
		window(8'h00, 1'b1);
		for (int r = 1; r < 4; r++) begin
			reset_all();
			cfg0(8'h00);
			cfg1(8'h48 | 8'(r << 4));
			window(8'h21, 1'b0);
			window(8'(34 + 4 * r - rem()), 1'b0);
			window(8'(35 + 4 * r - rem()), 1'b0);
		end
		reset_all();
		cfg1(8'h48);
		cfg0(8'hf0);
		window(8'h29, 1'b0);
		cfg0(8'h70);
		window(8'h24, 1'b0);
		window(8'h25, 1'b0);
		window(8'h21, 1'b0);
		cfg0(8'h08);
		window(8'h3c, 1'b0);
		cfg0(8'h04);
		pulse(1'b1);
		m_sync = 1'b1;
		@(negedge clk_in);
		cmp("gain held", 10'h001, 10'(gain_held_out));
		window(8'h3c, 1'b0);
		pulse(1'b0);
		{m_sync, m_ref_v} = 2'b00;
		window(8'h3c, 1'b0);
		cfg0(8'h0c);
		@(posedge clk_in);
		manual_gain_in <= 9'($random(seed));
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		cmp("manual gain", 10'(manual_gain_in), 10'(gain_out));
		cmp("gain held", 10'h001, 10'(gain_held_out));
		close_out();
	end
endmodule // acs_ctrl_tb_top
